// File: bench/bcl_ctrl_model.sv
// Display controller model driving shift clock, serial data and latch strobe.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module bcl_ctrl_model (
	output logic o_shift_clock,
	output logic o_serial_data_in,
	output logic o_latch_strobe
);
	// ==========
	// Idle: clock stands high between frames.
	initial begin
		o_shift_clock = 1'b1;
		o_serial_data_in = 1'b0;
		o_latch_strobe = 1'b0;
	end
	task automatic strobes(input int n);
		repeat (n) begin
			#60 o_latch_strobe = 1'b1;
			#60 o_latch_strobe = 1'b0;
		end
		#60;
	endtask : strobes
	task automatic frame(input logic [7:0] b);
		#7;
		for (int i = 7; i >= 0; i--) begin
			o_shift_clock = 1'b0;
			o_serial_data_in = b[i];
			#15 o_shift_clock = 1'b1;
			#15;
		end
		o_serial_data_in = ~b[0];
	endtask : frame
endmodule : bcl_ctrl_model

// File: bench/bcl_monitor.sv
// Port checker of the brightness configuration loader.
// Assumes it is bound into bcl_top.
`timescale 1ns/1ps
module bcl_monitor (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_serial_data_out,
	input wire logic [6:0] o_brightness_code_value,
	input wire logic o_open_detect_en,
	input wire logic o_short_detect_en,
	input wire logic o_brightness_mode,
	input wire logic [7:0] o_current_steps
);
	// ==========
	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
	a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
	a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data outside ack");
	a_detect_excl: assert property (o_open_detect_en != o_short_detect_en) else $error("detect select");
	a_steps_code: assert property (o_current_steps == {1'b0, o_brightness_code_value} + 8'h01)
		else $error("steps wrong");
	a_code_update: assert property ($changed({o_brightness_code_value, o_short_detect_en}) |->
		$past(o_brightness_mode) || $past(o_brightness_mode, 2)) else $error("code changed outside frame");
	a_serial_still: assert property (o_brightness_mode && $past(o_brightness_mode) |->
		$stable(o_serial_data_out)) else $error("chain moved in brightness mode");
	a_reset_vals: assert property ($fell(i_sys_rst) |-> o_brightness_code_value == 7'h5f &&
		o_open_detect_en && !o_brightness_mode) else $error("reset values");
	cover property ($rose(o_brightness_mode));
	cover property ($changed(o_brightness_code_value));
	cover property (o_wb_ack && o_wb_dat != 32'h0);
endmodule : bcl_monitor

bind bcl_top bcl_monitor bcl_monitor_inst (.i_core_clk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_wb_dat,
	.o_serial_data_out, .o_brightness_code_value, .o_open_detect_en, .o_short_detect_en, .o_brightness_mode,
	.o_current_steps);

// File: bench/tb_top.sv
// Self-checking bench of the brightness configuration loader.
// Assumes bcl_ctrl_model drives the link pins.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic [7:0] fr; logic [6:0] cd; logic fl; logic [7:0] st;} bcl_row_t;
	bcl_row_t rows [4] = '{'{8'hff, 7'h7f, 1'b1, 8'h80}, '{8'h00, 7'h00, 1'b0, 8'h01},
		'{8'hbf, 7'h5f, 1'b1, 8'h60}, '{8'h4a, 7'h25, 1'b0, 8'h26}};
	logic [2:0] dly [16] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7,
		3'h3, 3'h7, 3'h2, 3'h4, 3'h1, 3'h5, 3'h0, 3'h4};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd, dat;
	logic ack, sco, sdi, lat, sdo, oen, sen, mode;
	logic [6:0] code;
	logic [7:0] steps;
	wire [18:0] pins = {steps, sen, oen, mode, code, sdo};
	int compares = 0;
	int num_errors = 0;
	bcl_top bcl_top_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_shift_clock(sco), .i_serial_data_in(sdi),
		.i_latch_strobe(lat), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd),
		.i_wb_sel(4'hf), .o_wb_ack(ack), .o_wb_dat(dat), .o_serial_data_out(sdo),
		.o_brightness_code_value(code), .o_open_detect_en(oen), .o_short_detect_en(sen),
		.o_brightness_mode(mode), .o_current_steps(steps));
	bcl_ctrl_model bcl_ctrl_model_inst (.o_shift_clock(sco), .o_serial_data_in(sdi), .o_latch_strobe(lat));
	initial begin
		forever #5 clk = ~clk;
	end
	// ==========
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			num_errors++;
			close_out();
		end
		rd = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic wait_mode(input logic v);
		int n;
		n = 0;
		while (mode !== v && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (mode !== v) begin
			num_errors++;
			close_out();
		end
		repeat (3) @(negedge clk);
	endtask : wait_mode
	// ==========
	// Sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({13'h0, pins}, {13'h0, 8'h60, 1'b0, 1'b1, 1'b0, 7'h5f, 1'b0});
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h5f);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 8'h04, 32'h3);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h3);
		$display("test reset done");
		bcl_ctrl_model_inst.strobes(3);
		repeat (20) @(negedge clk);
		chk({31'h0, mode}, 32'h0);
		for (int i = 0; i < 32; i++) bcl_ctrl_model_inst.frame(8'ha5);
		$display("test short strobe run done");
		foreach (rows[i]) begin
			bcl_ctrl_model_inst.strobes(4);
			wait_mode(1'b1);
			bcl_ctrl_model_inst.frame(rows[i].fr);
			wait_mode(1'b0);
			chk({13'h0, pins}, {13'h0, rows[i].st, rows[i].fl, ~rows[i].fl, 1'b0, rows[i].cd, 1'b1});
			wb(1'b0, 8'h00, 32'h0);
			chk(rd, {23'h0, rows[i].fl, 1'b0, rows[i].cd});
		end
		$display("test brightness frames done");
		for (int ch = 0; ch < 16; ch++) begin
			wb(1'b1, 8'h04, {28'h0, ch[3:0]});
			wb(1'b0, 8'h08, 32'h0);
			chk(rd, {13'h0, dly[ch], 16'ha5a5});
		end
		$display("test luminance done");
		close_out();
	end
endmodule : tb_top

// File: design/bcl_lum_mem.sv
// Sixteen-word luminance latch store with registered read data.
// Assumes one clock; write and read share it.
`timescale 1ns/1ps

module bcl_lum_mem (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_we,
	input wire logic [3:0] i_waddr,
	input wire logic [15:0] i_wdata,
	input wire logic [3:0] i_raddr,
	output logic [15:0] o_rdata
);

	// ==========================================================
	// Storage
	logic [15:0] mem_q [0:15];
	logic [15:0] rdata_q;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= mem_q[i_raddr];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	assign o_rdata = rdata_q;

endmodule : bcl_lum_mem

// File: design/bcl_params.svh
// Constants of the brightness configuration loader: offsets, fields, resets and counts.
// Assumes inclusion by bcl_pkg.sv and bcl_top.sv.
`ifndef BCL_PARAMS_SVH
`define BCL_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define BCL_ADDR_W 8
`define BCL_OFS_STATUS 8'h00
`define BCL_OFS_CHSEL 8'h04
`define BCL_OFS_LUMDATA 8'h08

// ==========================================================
// Status and luminance data field positions
`define BCL_STAT_CODE_LSB 0
`define BCL_STAT_FLAG_BIT 8
`define BCL_STAT_MODE_BIT 9
`define BCL_LUM_DELAY_LSB 16

// ==========================================================
// Reset values and the full-scale code
`define BCL_CODE_RST 7'h5f
`define BCL_FLAG_RST 1'h0
`define BCL_FULL_CODE 7'h7f

// ==========================================================
// Counts
`define BCL_STROBE_COUNT 3'h4
`define BCL_FRAME_LAST 4'h7
`define BCL_CHANNELS 16
`define BCL_WORD_W 16
`define BCL_CHAIN_W 256
`define BCL_RING_W 3

// ==========================================================
// Turn-on stagger per channel, channel 15 in the top three bits
`define BCL_DELAY_TABLE {3'h4, 3'h0, 3'h5, 3'h1, 3'h4, 3'h2, 3'h7, 3'h3, \
	3'h7, 3'h3, 3'h6, 3'h2, 3'h5, 3'h1, 3'h4, 3'h0}

`endif

// File: design/bcl_pkg.sv
// Types of the brightness configuration loader.
// Assumes bcl_params.svh is on the include path.
`include "bcl_params.svh"

package bcl_pkg;

	// ==========================================================
	// Mode machine
	typedef enum logic [1:0] {
		BCL_NORMAL = 2'h1,
		BCL_BRIGHT = 2'h2
	} bcl_mode_t;

	// ==========================================================
	// Link-domain state
	typedef struct packed {
		logic [7:0] ring;
		logic [2:0] wp_bin;
		logic [2:0] wp_gray;
	} bcl_link_t;

	// ==========================================================
	// Core-domain state
	typedef struct packed {
		logic lat_s1;
		logic lat_s2;
		logic lat_d;
		logic clk_s1;
		logic clk_s2;
		logic [2:0] wp_s1;
		logic [2:0] wp_s2;
		logic [2:0] rd_ptr;
		bcl_mode_t mode;
		logic [2:0] strobe_cnt;
		logic [3:0] bit_cnt;
		logic [7:0] shadow;
		logic [6:0] code;
		logic flag;
		logic [7:0] steps;
		logic [255:0] chain;
		logic [3:0] latch_idx;
		logic [3:0] sel;
		logic ack;
		logic [31:0] dat;
	} bcl_core_t;

endpackage : bcl_pkg

// File: design/bcl_top.sv
// Brightness configuration loader of a sixteen-channel LED driver.
// Assumes a link clock from the display controller and a classic Wishbone master.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "bcl_params.svh"

// Behaviour
// - Frame: seven code bits MSB first, then flag.
// - Flag low open detect, high short detect.
// - Code resets to 1011111, 75 percent.
// - Four strobes, clock high, enter on fall.
// - Eight clock pulses load code and flag.
// - Code load leaves luminance data unchanged.
// - All-ones code gives full-scale current.
// - Channel turn-on delays follow fixed stagger.
// - Strobe high level moves chain into latches.
// - Flag resets low, open detection.
// - Serial bits sampled on rising clock.
module bcl_top
	import bcl_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_shift_clock,
	input wire logic i_serial_data_in,
	input wire logic i_latch_strobe,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output logic o_serial_data_out,
	output logic [6:0] o_brightness_code_value,
	output logic o_open_detect_en,
	output logic o_short_detect_en,
	output logic o_brightness_mode,
	output logic [7:0] o_current_steps
);

	// ==========================================================
	// Functions
	function automatic logic [2:0] bin2gray(input logic [2:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [2:0] gray2bin(input logic [2:0] g);
		gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
	endfunction : gray2bin

	function automatic logic [2:0] delay_of(input logic [3:0] ch);
		logic [47:0] tbl;
		tbl = `BCL_DELAY_TABLE;
		delay_of = tbl[ch * 3 +: 3];
	endfunction : delay_of

	function automatic logic [7:0] steps_of(input logic [6:0] code);
		steps_of = {1'b0, code} + 8'h01;
	endfunction : steps_of

	// ==========================================================
	// Link domain: every rising shift clock edge writes one bit into the ring.
	bcl_link_t lk_q;
	bcl_link_t lk_d;

	always_comb begin
		lk_d = lk_q;
		lk_d.ring[lk_q.wp_bin] = i_serial_data_in;
		lk_d.wp_bin = lk_q.wp_bin + 3'h1;
		lk_d.wp_gray = bin2gray(lk_d.wp_bin);
	end

	always_ff @(posedge i_shift_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// ==========================================================
	// Core domain
	bcl_core_t cq;
	bcl_core_t cd;
	logic mem_we;
	logic [3:0] mem_waddr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic have_bit;
	logic new_bit;
	logic lat_rise;
	logic lat_fall;
	logic wb_req;
	logic [7:0] frame;

	always_comb begin
		cd = cq;
		mem_we = 1'b0;
		mem_waddr = cq.latch_idx;
		mem_wdata = cq.chain[{cq.latch_idx, 4'h0} +: 16];
		frame = {cq.shadow[6:0], 1'b0};

		// Synchronisers for the strobe pin, the clock level and the write pointer.
		cd.lat_s1 = i_latch_strobe;
		cd.lat_s2 = cq.lat_s1;
		cd.lat_d = cq.lat_s2;
		cd.clk_s1 = i_shift_clock;
		cd.clk_s2 = cq.clk_s1;
		cd.wp_s1 = lk_q.wp_gray;
		cd.wp_s2 = cq.wp_s1;

		lat_rise = cq.lat_s2 & ~cq.lat_d;
		lat_fall = ~cq.lat_s2 & cq.lat_d;
		have_bit = (cq.rd_ptr != gray2bin(cq.wp_s2));
		new_bit = lk_q.ring[cq.rd_ptr];

		if (have_bit) begin
			cd.rd_ptr = cq.rd_ptr + 3'h1;
		end

		case (cq.mode)
			BCL_NORMAL: begin
				if (have_bit) begin
					cd.chain = {cq.chain[254:0], new_bit};
					cd.strobe_cnt = 3'h0;
				end else if (lat_rise) begin
					if (cq.clk_s2) begin
						if (cq.strobe_cnt != `BCL_STROBE_COUNT) begin
							cd.strobe_cnt = cq.strobe_cnt + 3'h1;
						end
					end else begin
						cd.strobe_cnt = 3'h0;
					end
				end else if (lat_fall) begin
					if (cq.clk_s2 && cq.strobe_cnt == `BCL_STROBE_COUNT) begin
						cd.mode = BCL_BRIGHT;
						cd.bit_cnt = 4'h0;
					end
					if (!cq.clk_s2) begin
						cd.strobe_cnt = 3'h0;
					end
				end
				// A sweep that a strobe starts runs through all sixteen words once the strobe has fallen, unless that fall enters brightness mode and clears latch_idx.
				if (cq.lat_s2 || cq.latch_idx != 4'h0) begin
					mem_we = 1'b1;
					cd.latch_idx = cq.latch_idx + 4'h1;
				end else begin
					cd.latch_idx = 4'h0;
				end
			end
			BCL_BRIGHT: begin
				cd.latch_idx = 4'h0;
				if (have_bit) begin
					frame = {cq.shadow[6:0], new_bit};
					cd.shadow = frame;
					cd.bit_cnt = cq.bit_cnt + 4'h1;
					if (cq.bit_cnt == `BCL_FRAME_LAST) begin
						cd.code = frame[7:1];
						cd.flag = frame[0];
						cd.steps = steps_of(frame[7:1]);
						cd.mode = BCL_NORMAL;
						cd.strobe_cnt = 3'h0;
					end
				end
			end
			default: begin
				cd.mode = BCL_NORMAL;
			end
		endcase

		// Wishbone slave: one-cycle ack, unmapped reads return zero.
		wb_req = i_wb_cyc & i_wb_stb & ~cq.ack;
		cd.ack = wb_req;
		cd.dat = 32'h0000_0000;
		if (wb_req) begin
			if (i_wb_adr == `BCL_OFS_STATUS) begin
				cd.dat[`BCL_STAT_CODE_LSB +: 7] = cq.code;
				cd.dat[`BCL_STAT_FLAG_BIT] = cq.flag;
				cd.dat[`BCL_STAT_MODE_BIT] = (cq.mode == BCL_BRIGHT);
			end else if (i_wb_adr == `BCL_OFS_CHSEL) begin
				cd.dat[3:0] = cq.sel;
				if (i_wb_we && i_wb_sel[0]) begin
					cd.sel = i_wb_dat[3:0];
				end
			end else if (i_wb_adr == `BCL_OFS_LUMDATA) begin
				cd.dat[15:0] = mem_rdata;
				cd.dat[`BCL_LUM_DELAY_LSB +: 3] = delay_of(cq.sel);
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cq <= '0;
			cq.mode <= BCL_NORMAL;
			cq.code <= `BCL_CODE_RST;
			cq.flag <= `BCL_FLAG_RST;
			cq.steps <= 8'h60;
		end else begin
			cq <= cd;
		end
	end

	// ==========================================================
	// Luminance latches
	bcl_lum_mem u_mem (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_raddr(cq.sel),
		.o_rdata(mem_rdata)
	);

	// ==========================================================
	// Outputs
	assign o_wb_ack = cq.ack;
	assign o_wb_dat = cq.dat;
	assign o_serial_data_out = cq.chain[255];
	assign o_brightness_code_value = cq.code;
	assign o_open_detect_en = ~cq.flag;
	assign o_short_detect_en = cq.flag;
	assign o_brightness_mode = (cq.mode == BCL_BRIGHT);
	assign o_current_steps = cq.steps;

endmodule : bcl_top
